// >>> ass_pkg.sv
package ass_pkg;
	localparam int ass_addr_w = 22;
	localparam int ass_bank_w = 2;
	localparam int ass_data_w = 16;
	localparam int ass_be_w = 2;
	localparam int ass_cnt_w = 6;
	localparam int ass_ta_w = 2;
	localparam logic [ass_cnt_w-1:0] ass_cnt_zero = 6'h00;
	localparam logic [ass_cnt_w-1:0] ass_cnt_one = 6'h01;
	localparam logic [ass_ta_w-1:0] ass_ta_zero = 2'h0;
	localparam logic [ass_ta_w-1:0] ass_ta_one = 2'h1;
	localparam logic [2:0] ass_sub_zero = 3'h0;
	localparam logic [2:0] ass_sub_one = 3'h1;

	// Timing fields of the async configuration register
	typedef struct packed {
		logic [ass_ta_w-1:0] turnaround_count;
		logic [ass_cnt_w-1:0] r_setup;
		logic [ass_cnt_w-1:0] r_strobe;
		logic [ass_cnt_w-1:0] r_hold;
		logic [ass_cnt_w-1:0] w_setup;
		logic [ass_cnt_w-1:0] w_strobe;
		logic [ass_cnt_w-1:0] w_hold;
	} ass_cfg_type;

	// One word request from the internal requestors
	typedef struct packed {
		logic write;
		logic [ass_addr_w-1:0] addr;
		logic [ass_bank_w-1:0] bank;
		logic [ass_data_w-1:0] wdata;
		logic [ass_be_w-1:0] be;
		logic [2:0] subs;
	} ass_req_type;

	typedef enum logic [2:0] {
		ass_idle,
		ass_turn,
		ass_setup,
		ass_strobe,
		ass_hold
	} ass_state_type;
endpackage

// >>> ass_sequencer.sv
// Summary of operation
// - Read strobe end edge raises chip select and output enable.
// - Data bus is captured as read data at end of read strobe.
// - Strobe is stretched while the external hold-off input is asserted.
// - Address and bank outputs are no longer guaranteed after read hold.
// - Byte enables are no longer guaranteed after read hold.
// - Further sub-accesses of one word go straight to setup, no turnaround.
// - Sub-accesses keep the timing counts captured at the first access.
// - After a word, return to idle or enter pending request's turnaround.
// - A write starts only once it is the highest priority task.
// - A multi-access write runs successive access cycles until complete.
// - Output enable stays high throughout every write.
// - Turnaround cycles from the turnaround count precede write setup.
// - Write directly after write inserts no turnaround cycles.
// - Write after read with zero turnaround count inserts one cycle.
// - After turnaround, priority is rechecked; lost priority abandons.
// - Write setup loads counters from write setup, strobe, hold fields.
// - Write setup drives address, bank and write data onto the bus.
// - Write setup drives direction low unless it is already low.
// - Write setup activates byte enables for the written bytes.
// - Read setup loads counters from read setup, strobe, hold fields.
// - Read strobe start drives chip select and output enable low.
// - Write strobe start drives chip select and write strobe low, end raises.
// - Direction returns high at write hold end when no accesses remain.
module ass_sequencer
	import ass_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire ass_cfg_type async_config_reg,
	input wire ass_req_type req,
	input wire logic req_valid,
	input wire logic req_top_priority,
	output logic req_taken,
	output logic req_done,
	output logic req_abandoned,
	output logic [ass_data_w-1:0] rdata,
	output logic rdata_valid,
	output logic busy,
	output logic async_chip_select_n,
	output logic output_enable_n,
	output logic write_strobe_n,
	output logic direction_out,
	output logic [ass_addr_w-1:0] ext_address_bus,
	output logic [ass_bank_w-1:0] ext_bank_select,
	output logic [ass_be_w-1:0] byte_enable_n,
	input wire logic [ass_data_w-1:0] ext_data_bus_in,
	output logic [ass_data_w-1:0] ext_data_bus_out,
	output logic ext_data_bus_oe,
	input wire logic ext_hold_off_in
);
	ass_state_type state_reg, state_next;
	ass_req_type cur_reg, cur_next;
	logic [ass_cnt_w-1:0] cnt_reg, cnt_next;
	logic [ass_cnt_w-1:0] stb_reg, stb_next;
	logic [ass_cnt_w-1:0] hld_reg, hld_next;
	// Setup count kept for the follow-on accesses of one word
	logic [ass_cnt_w-1:0] stp_reg, stp_next;
	logic [ass_ta_w-1:0] ta_reg, ta_next;
	logic [2:0] left_reg, left_next;
	logic last_valid_reg, last_valid_next;
	logic last_write_reg, last_write_next;
	logic cs_reg, cs_next;
	logic oe_reg, oe_next;
	logic we_reg, we_next;
	logic dir_reg, dir_next;
	logic [ass_addr_w-1:0] a_reg, a_next;
	logic [ass_bank_w-1:0] ba_reg, ba_next;
	logic [ass_be_w-1:0] be_reg, be_next;
	logic [ass_data_w-1:0] dout_reg, dout_next;
	logic [ass_data_w-1:0] rd_reg, rd_next;
	logic doe_reg, doe_next;
	logic rdv_reg, rdv_next;
	logic tk_reg, tk_next;
	logic dn_reg, dn_next;
	logic ab_reg, ab_next;
	// Registered so that busy leaves a flip-flop like every other output
	logic busy_reg, busy_next;

	// Turnaround length for a request following the last finished access
	function automatic logic [ass_ta_w-1:0] ta_len(input logic wr, input logic lv, input logic lw,
		input logic [ass_ta_w-1:0] field);
		if (lv && (wr == lw)) begin
			return ass_ta_zero;
		end else if (lv && (field == ass_ta_zero)) begin
			return ass_ta_one;
		end else begin
			return field;
		end
	endfunction

	always_comb begin
		state_next = state_reg;
		cur_next = cur_reg;
		cnt_next = cnt_reg;
		stb_next = stb_reg;
		hld_next = hld_reg;
		stp_next = stp_reg;
		ta_next = ta_reg;
		left_next = left_reg;
		last_valid_next = last_valid_reg;
		last_write_next = last_write_reg;
		cs_next = cs_reg;
		oe_next = oe_reg;
		we_next = we_reg;
		dir_next = dir_reg;
		a_next = a_reg;
		ba_next = ba_reg;
		be_next = be_reg;
		dout_next = dout_reg;
		doe_next = doe_reg;
		rd_next = rd_reg;
		rdv_next = 1'b0;
		tk_next = 1'b0;
		dn_next = 1'b0;
		ab_next = 1'b0;
		case (state_reg)
			// The first access after reset takes the full turnaround field
			ass_idle: begin
				if (req_valid && req_top_priority) begin
					cur_next = req;
					tk_next = 1'b1;
					ta_next = ta_len(req.write, last_valid_reg, last_write_reg,
						async_config_reg.turnaround_count);
					state_next = ass_turn;
				end
			end
			ass_turn: begin
				// Count the turnaround down, then look at priority once more
				if (ta_reg != ass_ta_zero) begin
					ta_next = ta_reg - ass_ta_one;
				end else if (!(req_valid && req_top_priority)) begin
					ab_next = 1'b1;
					state_next = ass_idle;
				end else begin
					// Only the first access of a word loads its counts from the fields
					left_next = (cur_reg.subs == ass_sub_zero) ? ass_sub_zero : cur_reg.subs - ass_sub_one;
					if (cur_reg.write) begin
						cnt_next = async_config_reg.w_setup;
						stb_next = async_config_reg.w_strobe;
						hld_next = async_config_reg.w_hold;
						stp_next = async_config_reg.w_setup;
						dout_next = cur_reg.wdata;
						doe_next = 1'b1;
						dir_next = 1'b0;
					end else begin
						cnt_next = async_config_reg.r_setup;
						stb_next = async_config_reg.r_strobe;
						hld_next = async_config_reg.r_hold;
						stp_next = async_config_reg.r_setup;
						doe_next = 1'b0;
					end
					a_next = cur_reg.addr;
					ba_next = cur_reg.bank;
					// Byte mask is active high on the request side and low on the pins
					be_next = ~cur_reg.be;
					oe_next = 1'b1;
					state_next = ass_setup;
				end
			end
			// A field of zero still gives one cycle in each period
			ass_setup: begin
				if (cnt_reg > ass_cnt_one) begin
					cnt_next = cnt_reg - ass_cnt_one;
				end else begin
					cnt_next = stb_reg;
					cs_next = 1'b0;
					if (cur_reg.write) begin
						we_next = 1'b0;
					end else begin
						oe_next = 1'b0;
					end
					state_next = ass_strobe;
				end
			end
			// The device may keep the strobe open past its count
			ass_strobe: begin
				if (cnt_reg > ass_cnt_one) begin
					cnt_next = cnt_reg - ass_cnt_one;
				end else if (!ext_hold_off_in) begin
					cs_next = 1'b1;
					oe_next = 1'b1;
					we_next = 1'b1;
					// Sampled on the edge that closes the strobe
					if (!cur_reg.write) begin
						rd_next = ext_data_bus_in;
						rdv_next = 1'b1;
					end
					cnt_next = hld_reg;
					state_next = ass_hold;
				end
			end
			// The last hold cycle either starts the next access or closes the word
			ass_hold: begin
				if (cnt_reg > ass_cnt_one) begin
					cnt_next = cnt_reg - ass_cnt_one;
				end else if (left_reg != ass_sub_zero) begin
					// Counts kept from the first access
					left_next = left_reg - ass_sub_one;
					cnt_next = stp_reg;
					a_next = a_reg + {{(ass_addr_w-1){1'b0}}, 1'b1};
					state_next = ass_setup;
				end else begin
					// Data bus, byte enables and direction are released once the hold ends; address and bank keep their values
					doe_next = 1'b0;
					be_next = {ass_be_w{1'b1}};
					dir_next = 1'b1;
					dn_next = 1'b1;
					last_valid_next = 1'b1;
					last_write_next = cur_reg.write;
					// The word just served still reads as pending here unless the requestor
					// withdrew it after setup began; it would then be run a second time
					if (req_valid && req_top_priority) begin
						cur_next = req;
						tk_next = 1'b1;
						ta_next = ta_len(req.write, 1'b1, cur_reg.write,
							async_config_reg.turnaround_count);
						state_next = ass_turn;
					end else begin
						state_next = ass_idle;
					end
				end
			end
			default: state_next = ass_idle;
		endcase
		// Busy follows the state that the next edge will hold
		busy_next = (state_next != ass_idle);
	end

	// Pins are registered, so each change lands on a rising edge
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_reg <= ass_idle;
			cur_reg <= '0;
			cnt_reg <= ass_cnt_zero;
			stb_reg <= ass_cnt_zero;
			hld_reg <= ass_cnt_zero;
			stp_reg <= ass_cnt_zero;
			ta_reg <= ass_ta_zero;
			left_reg <= ass_sub_zero;
			last_valid_reg <= 1'b0;
			last_write_reg <= 1'b0;
			cs_reg <= 1'b1;
			oe_reg <= 1'b1;
			we_reg <= 1'b1;
			dir_reg <= 1'b1;
			a_reg <= '0;
			ba_reg <= '0;
			be_reg <= '1;
			dout_reg <= '0;
			doe_reg <= 1'b0;
			rd_reg <= '0;
			rdv_reg <= 1'b0;
			tk_reg <= 1'b0;
			dn_reg <= 1'b0;
			ab_reg <= 1'b0;
			busy_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cur_reg <= cur_next;
			cnt_reg <= cnt_next;
			stb_reg <= stb_next;
			hld_reg <= hld_next;
			stp_reg <= stp_next;
			ta_reg <= ta_next;
			left_reg <= left_next;
			last_valid_reg <= last_valid_next;
			last_write_reg <= last_write_next;
			cs_reg <= cs_next;
			oe_reg <= oe_next;
			we_reg <= we_next;
			dir_reg <= dir_next;
			a_reg <= a_next;
			ba_reg <= ba_next;
			be_reg <= be_next;
			dout_reg <= dout_next;
			doe_reg <= doe_next;
			rd_reg <= rd_next;
			rdv_reg <= rdv_next;
			tk_reg <= tk_next;
			dn_reg <= dn_next;
			ab_reg <= ab_next;
			busy_reg <= busy_next;
		end
	end

	// Outputs are the registers themselves; nothing combinational reaches a pin
	assign async_chip_select_n = cs_reg;
	assign output_enable_n = oe_reg;
	assign write_strobe_n = we_reg;
	assign direction_out = dir_reg;
	assign ext_address_bus = a_reg;
	assign ext_bank_select = ba_reg;
	assign byte_enable_n = be_reg;
	assign ext_data_bus_out = dout_reg;
	assign ext_data_bus_oe = doe_reg;
	assign rdata = rd_reg;
	assign rdata_valid = rdv_reg;
	assign req_taken = tk_reg;
	assign req_done = dn_reg;
	assign req_abandoned = ab_reg;
	assign busy = busy_reg;
endmodule

// >>> ass_seq_chk.sv
module ass_seq_chk
	import ass_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire ass_req_type req,
	input wire logic req_valid,
	input wire logic req_top_priority,
	input wire logic req_taken,
	input wire logic req_abandoned,
	input wire logic req_done,
	input wire logic busy,
	input wire logic [ass_data_w-1:0] rdata,
	input wire logic rdata_valid,
	input wire logic async_chip_select_n,
	input wire logic output_enable_n,
	input wire logic write_strobe_n,
	input wire logic direction_out,
	input wire logic [ass_bank_w-1:0] ext_bank_select,
	input wire logic [ass_be_w-1:0] byte_enable_n,
	input wire logic [ass_data_w-1:0] ext_data_bus_in,
	input wire logic [ass_data_w-1:0] ext_data_bus_out,
	input wire logic ext_data_bus_oe,
	input wire logic ext_hold_off_in
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	property p_rd_end; $rose(output_enable_n) |-> async_chip_select_n && rdata_valid; endproperty
	a_rd_end: assert property (p_rd_end) else $error("read strobe end wrong");
	property p_rd_data; rdata_valid |-> rdata == $past(ext_data_bus_in); endproperty
	a_rd_data: assert property (p_rd_data) else $error("read data not sampled");
	property p_wait; !output_enable_n && ext_hold_off_in |=> !output_enable_n; endproperty
	a_wait: assert property (p_wait) else $error("strobe not stretched");
	property p_oe_wr; !write_strobe_n |-> output_enable_n && !async_chip_select_n; endproperty
	a_oe_wr: assert property (p_oe_wr) else $error("write strobe pins wrong");
	property p_dir; !write_strobe_n |-> !direction_out && ext_data_bus_oe && ext_data_bus_out == req.wdata; endproperty
	a_dir: assert property (p_dir) else $error("write bus not driven");
	property p_be; !async_chip_select_n |-> byte_enable_n == ~req.be && ext_bank_select == req.bank; endproperty
	a_be: assert property (p_be) else $error("byte enables or bank wrong");
	property p_abandon; req_abandoned |-> async_chip_select_n && write_strobe_n && output_enable_n; endproperty
	a_abandon: assert property (p_abandon) else $error("pins moved on abandon");
	property p_taken; req_taken |-> $past(req_valid && req_top_priority); endproperty
	a_taken: assert property (p_taken) else $error("request taken without priority");
	property p_cs_oe; !output_enable_n |-> !async_chip_select_n && write_strobe_n; endproperty
	a_cs_oe: assert property (p_cs_oe) else $error("read strobe pins wrong");
	property p_dir_hi; $rose(direction_out) |-> req_done; endproperty
	a_dir_hi: assert property (p_dir_hi) else $error("direction rose outside word end");
	property p_hold_end;
		req_done |-> byte_enable_n == '1 && !ext_data_bus_oe && async_chip_select_n && output_enable_n;
	endproperty
	a_hold_end: assert property (p_hold_end) else $error("pins still held after word end");
	property p_idle; !busy |-> async_chip_select_n && output_enable_n && write_strobe_n; endproperty
	a_idle: assert property (p_idle) else $error("strobes active while idle");
endmodule
bind ass_sequencer ass_seq_chk u_chk (.mclk, .rst, .req, .req_valid, .req_top_priority, .req_taken, .req_abandoned,
	.req_done, .busy,
	.rdata, .rdata_valid, .async_chip_select_n, .output_enable_n, .write_strobe_n, .direction_out, .ext_bank_select,
	.byte_enable_n, .ext_data_bus_in, .ext_data_bus_out, .ext_data_bus_oe, .ext_hold_off_in);

// >>> ass_mem_model.sv
module ass_mem_model
	import ass_pkg::*;
(
	input wire logic mclk,
	input wire logic stretch,
	input wire logic async_chip_select_n,
	input wire logic output_enable_n,
	input wire logic write_strobe_n,
	input wire logic [ass_addr_w-1:0] ext_address_bus,
	input wire logic [ass_data_w-1:0] ext_data_bus_out,
	output logic [ass_data_w-1:0] ext_data_bus_in,
	output logic ext_hold_off_in
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [ass_data_w-1:0] mem [16] = '{default: '0};
	logic [ass_data_w-1:0] last = '0;
	logic [1:0] hcnt = '0;
	always @(posedge mclk) begin
		if (!write_strobe_n && !async_chip_select_n)
			mem[ext_address_bus[3:0]] <= ext_data_bus_out;
		if (async_chip_select_n)
			hcnt <= {stretch, stretch};
		else if (hcnt != 2'h0)
			hcnt <= hcnt - 2'h1;
		if (!output_enable_n)
			last <= ext_data_bus_in;
	end
	// Slow device: holds the strobe off for three cycles when asked
	assign ext_hold_off_in = !async_chip_select_n && hcnt != 2'h0;
	// Undriven bus shows the inverse of its last value, never a stale match
	assign ext_data_bus_in = (!async_chip_select_n && !output_enable_n) ? mem[ext_address_bus[3:0]] : ~last;
endmodule

// >>> testbench.sv
module testbench;
	import ass_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 0, rst = 1, req_valid = 0, req_top_priority = 0, stretch = 0, last_w = 0;
	ass_cfg_type async_config_reg = '0;
	ass_req_type req = '0;
	logic req_taken, req_done, req_abandoned, rdata_valid, busy, ext_data_bus_oe, ext_hold_off_in;
	logic async_chip_select_n, output_enable_n, write_strobe_n, direction_out;
	logic [ass_data_w-1:0] rdata, ext_data_bus_in, ext_data_bus_out;
	logic [ass_addr_w-1:0] ext_address_bus;
	logic [ass_bank_w-1:0] ext_bank_select;
	logic [ass_be_w-1:0] byte_enable_n;
	logic [15:0] shadow [16] = '{default: '0};
	logic [15:0] exp_q [$];
	logic [31:0] rnd = 32'h643e52d9;
	int n_mismatch = 0, comparisons = 0;
	ass_sequencer uut (.*);
	ass_mem_model u_mem (.*);
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic compare(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish;
		if (n_mismatch == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic do_req(input logic w, input logic [1:0] a, input logic [15:0] d, input logic [2:0] s, input logic drop);
		int k;
		k = 0;
		req <= '{write: w, addr: {20'h0, a}, bank: a, wdata: d, be: 2'h3, subs: s};
		req_valid <= 1'b1;
		req_top_priority <= 1'b1;
		// Each sub-access hits the next address
		for (int j = 0; j < ((s == 3'h0) ? 1 : s); j++)
			if (drop) ;
			else if (w) shadow[a + j] = d;
			else exp_q.push_back(shadow[a + j]);
		do begin
			@(negedge mclk);
			k++;
		end while (req_taken !== 1'b1 && k < 500);
		k = 0;
		if (drop) begin
			@(posedge mclk) req_top_priority <= 1'b0;
		end else begin
			// Withdrawn once setup starts, so the hold end does not take the same word again
			do begin
				@(negedge mclk);
				k++;
			end while (byte_enable_n === 2'h3 && k < 500);
			@(posedge mclk) req_valid <= 1'b0;
		end
		k = 0;
		do begin
			@(negedge mclk);
			k++;
		end while (req_done !== 1'b1 && req_abandoned !== 1'b1 && k < 900);
		compare(16'(req_abandoned), 16'(drop));
		compare(16'(req_done), 16'(!drop));
		@(posedge mclk) req_valid <= 1'b0;
		if (!drop)
			last_w = w;
	endtask
	initial forever #50 mclk = ~mclk;
	always @(negedge mclk)
		if (rdata_valid === 1'b1) begin
			compare(16'(exp_q.size() > 0), 16'h0001);
			if (exp_q.size() > 0)
				compare(rdata, exp_q.pop_front());
		end
	initial begin
		#2_000_000;
		n_mismatch++;
		tally_and_finish();
	end
	initial begin
		logic drop;
		repeat (12) @(posedge mclk);
		rst <= 1'b0;
		for (int i = 0; i < 48; i++) begin
			rnd = lfsr(rnd);
			drop = (i % 8 == 5);
			@(posedge mclk);
			// Abandon runs use a long opposite-direction turnaround so the recheck comes late
			async_config_reg <= {drop ? 2'h3 : rnd[1:0], 3'h0, rnd[4:2], 3'h0, rnd[7:5], 3'h0, rnd[10:8],
				3'h0, rnd[13:11], 3'h0, rnd[16:14], 3'h0, rnd[19:17]};
			stretch <= rnd[28];
			do_req(drop ? !last_w : rnd[20], rnd[22:21], rnd[31:16], rnd[27:25], drop);
		end
		compare(16'(exp_q.size()), 16'h0000);
		tally_and_finish();
	end
endmodule
